//--- rfd_pkg.sv
// rfd_pkg: register map, field layout and reset values of the antenna driver signal select block
// assumes an AHB-Lite register port with 32-bit data and one aligned word per register
`default_nettype none
package rfd_pkg;
  localparam logic [7:0] RFD_TXCTRL_OFS = 8'h00;
  localparam logic [7:0] RFD_GS_OFS = 8'h04;
  localparam logic [7:0] RFD_TXSEL_OFS = 8'h08;
  localparam logic [7:0] RFD_RXSEL_OFS = 8'h0C;
  localparam logic [7:0] RFD_STATUS_OFS = 8'h10;
  // control register bit positions
  localparam int RFD_B_D1_ON = 0;
  localparam int RFD_B_D2_ON = 1;
  localparam int RFD_B_FORCE = 2;
  localparam int RFD_B_D2_CW = 3;
  localparam int RFD_B_D1_INV_ON = 4;
  localparam int RFD_B_D1_INV_OFF = 5;
  localparam int RFD_B_D2_INV_ON = 6;
  localparam int RFD_B_D2_INV_OFF = 7;
  // conductance register: four 6-bit fields
  localparam int RFD_GS_W = 6;
  localparam int RFD_GS_PCW_LSB = 0;
  localparam int RFD_GS_POSITIVE_MODULATED_CONDUCTANCE_LSB = 8;
  localparam int RFD_GS_NCW_LSB = 16;
  localparam int RFD_GS_NEGATIVE_MODULATED_CONDUCTANCE_LSB = 24;
  localparam logic [7:0] RFD_TXCTRL_RST = 8'h00;
  localparam logic [31:0] RFD_GS_RST = 32'h20_3F_20_3F;
  localparam logic [3:0] RFD_MOUT_RST = 4'h0;
  localparam logic [1:0] RFD_RXSRC_RST = 2'h0;
  localparam logic [1:0] RFD_DRVSRC_RST = 2'h0;
  // select encodings
  localparam logic [3:0] RFD_MOUT_LOW = 4'h0;
  localparam logic [3:0] RFD_MOUT_ENV = 4'h1;
  localparam logic [3:0] RFD_MOUT_RXIN = 4'h2;
  localparam logic [3:0] RFD_MOUT_MILLER = 4'h4;
  localparam logic [1:0] RFD_RXSRC_INT = 2'h0;
  localparam logic [1:0] RFD_RXSRC_MODEM = 2'h1;
  localparam logic [1:0] RFD_DRVSRC_CODER = 2'h0;
  localparam logic [1:0] RFD_DRVSRC_MODEM = 2'h1;
  localparam int RFD_MAX_KBPS = 848;
  localparam int RFD_CLK_MHZ = 100;
endpackage
`default_nettype wire

//--- rfd_signal_select.sv
// rfd_signal_select: carrier, driver waveform, conductance select and serial routing
// assumes hclk is the crystal clock; one AHB-Lite master; modem pin is asynchronous
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module rfd_signal_select #(
  parameter int GS_W = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic coder_envelope,
  input wire logic miller_coder_out,
  input wire logic modem_input_pin,
  input wire logic analog_rx_in,
  output logic first_antenna_output,
  output logic second_antenna_output,
  output logic [5:0] first_positive_conductance,
  output logic [5:0] first_negative_array_conductance,
  output logic [5:0] second_positive_conductance,
  output logic [5:0] second_negative_array_conductance,
  output logic modem_output_pin,
  output logic decoder_input
);
  import rfd_pkg::*;

  if (GS_W != RFD_GS_W) begin : g_bad_gs_w
    $error("GS_W must match the register field width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always OKAY
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] txctrl_q;
  logic [31:0] gs_q;
  logic [3:0] modem_output_select_q;
  logic [1:0] receive_source_select_q;
  logic [1:0] driver_source_select_q;
  logic [31:0] hrdata_q;
  logic addr_ok;
  logic [31:0] status_w;

  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txctrl_q <= RFD_TXCTRL_RST;
      gs_q <= RFD_GS_RST;
      modem_output_select_q <= RFD_MOUT_RST;
      receive_source_select_q <= RFD_RXSRC_RST;
      driver_source_select_q <= RFD_DRVSRC_RST;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        RFD_TXCTRL_OFS: txctrl_q <= hwdata[7:0];
        RFD_GS_OFS: gs_q <= hwdata;
        RFD_TXSEL_OFS: begin
          modem_output_select_q <= hwdata[3:0];
          driver_source_select_q <= hwdata[5:4];
        end
        RFD_RXSEL_OFS: receive_source_select_q <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // unmapped reads answer zero, writes there are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      unique case (haddr)
        RFD_TXCTRL_OFS: hrdata_q <= {24'h00_0000, txctrl_q};
        RFD_GS_OFS: hrdata_q <= gs_q & 32'h3F_3F_3F_3F;
        RFD_TXSEL_OFS: hrdata_q <= {26'h0, driver_source_select_q, modem_output_select_q};
        RFD_RXSEL_OFS: hrdata_q <= {30'h0, receive_source_select_q};
        RFD_STATUS_OFS: hrdata_q <= status_w;
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end else begin
      hrdata_q <= 32'h0000_0000;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // carrier from the crystal clock
  logic carrier_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) carrier_q <= 1'b0;
    else carrier_q <= ~carrier_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // modem pin synchroniser: change counts once stages two and three agree
  logic [2:0] min_sync_q;
  logic min_stable_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      min_sync_q <= 3'b000;
      min_stable_q <= 1'b0;
    end else begin
      min_sync_q <= {min_sync_q[1:0], modem_input_pin};
      if (min_sync_q[2] == min_sync_q[1]) min_stable_q <= min_sync_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // driver waveform and conductance select
  logic envelope;
  logic d1_on, d2_on, force_full_depth_keying, second_driver_unmodulated;
  logic first_driver_invert_when_on, second_driver_invert_when_on;
  logic inverted_carrier;
  logic tx1_d, tx2_d;
  logic [5:0] positive_unmodulated_setting, positive_modulated_setting;
  logic [5:0] negative_unmodulated_setting, negative_modulated_setting;
  logic [5:0] p_sel1, n_sel1, p_sel2, n_sel2;

  // external modem can feed the driver envelope instead of the coder
  assign envelope = (driver_source_select_q == RFD_DRVSRC_MODEM) ? min_stable_q : coder_envelope;
  assign d1_on = txctrl_q[RFD_B_D1_ON];
  assign d2_on = txctrl_q[RFD_B_D2_ON];
  assign force_full_depth_keying = txctrl_q[RFD_B_FORCE];
  assign second_driver_unmodulated = txctrl_q[RFD_B_D2_CW];
  assign first_driver_invert_when_on = txctrl_q[RFD_B_D1_INV_ON];
  assign second_driver_invert_when_on = txctrl_q[RFD_B_D2_INV_ON];
  // current carrier phase, so registered it runs opposite carrier_q; its inverse lines up with carrier_q
  assign inverted_carrier = carrier_q;
  assign positive_unmodulated_setting = gs_q[RFD_GS_PCW_LSB +: RFD_GS_W];
  assign positive_modulated_setting = gs_q[RFD_GS_POSITIVE_MODULATED_CONDUCTANCE_LSB +: RFD_GS_W];
  assign negative_unmodulated_setting = gs_q[RFD_GS_NCW_LSB +: RFD_GS_W];
  assign negative_modulated_setting = gs_q[RFD_GS_NEGATIVE_MODULATED_CONDUCTANCE_LSB +: RFD_GS_W];

  // off-state inversion bits only matter without forced keying, and there
  // the carrier runs unchanged, so they have no effect on the waveform
  always_comb begin
    tx1_d = 1'b0;
    tx2_d = 1'b0;
    if (d1_on) begin
      if (force_full_depth_keying && !envelope) tx1_d = 1'b0;
      else if (force_full_depth_keying && first_driver_invert_when_on) tx1_d = inverted_carrier;
      else tx1_d = ~inverted_carrier;
    end
    if (d2_on) begin
      if (force_full_depth_keying && !second_driver_unmodulated && !envelope) tx2_d = 1'b0;
      else if (second_driver_invert_when_on) tx2_d = inverted_carrier;
      else tx2_d = ~inverted_carrier;
    end
  end

  // the same setting pair feeds both arrays unless second_driver_unmodulated puts the second driver on the unmodulated pair
  always_comb begin
    p_sel1 = envelope ? positive_unmodulated_setting : positive_modulated_setting;
    n_sel1 = envelope ? negative_unmodulated_setting : negative_modulated_setting;
    p_sel2 = p_sel1;
    n_sel2 = n_sel1;
    if (second_driver_unmodulated) begin
      p_sel2 = positive_unmodulated_setting;
      n_sel2 = negative_unmodulated_setting;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_antenna_output <= 1'b0;
      second_antenna_output <= 1'b0;
      first_positive_conductance <= 6'h00;
      first_negative_array_conductance <= 6'h00;
      second_positive_conductance <= 6'h00;
      second_negative_array_conductance <= 6'h00;
    end else begin
      first_antenna_output <= tx1_d;
      second_antenna_output <= tx2_d;
      first_positive_conductance <= p_sel1;
      first_negative_array_conductance <= n_sel1;
      second_positive_conductance <= p_sel2;
      second_negative_array_conductance <= n_sel2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial data switch toward modem pins and decoder
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      modem_output_pin <= 1'b0;
      decoder_input <= 1'b0;
    end else begin
      unique case (modem_output_select_q)
        RFD_MOUT_MILLER: modem_output_pin <= miller_coder_out;
        RFD_MOUT_ENV: modem_output_pin <= coder_envelope;
        RFD_MOUT_RXIN: modem_output_pin <= analog_rx_in;
        default: modem_output_pin <= 1'b0;
      endcase
      // only one rf path feeds the decoder at a time
      if (receive_source_select_q == RFD_RXSRC_MODEM) decoder_input <= min_stable_q;
      else decoder_input <= analog_rx_in;
    end
  end

  // top speed is a property of the core timing, reported read-only
  assign status_w = {4'h0, 12'(RFD_MAX_KBPS), 8'h00, 5'h00, carrier_q, d2_on, d1_on};

  ////////////////////////////////////////////////////////////////////////////
  property p_carrier_toggles;
    @(posedge hclk) disable iff (!hresetn) hresetn |=> (carrier_q != $past(carrier_q));
  endproperty
  a_carrier_toggles: assert property (p_carrier_toggles) else $error("carrier did not toggle");

  property p_tx1_follows;
    @(posedge hclk) disable iff (!hresetn)
      (d1_on && !force_full_depth_keying) |=> (first_antenna_output == carrier_q);
  endproperty
  a_tx1_follows: assert property (p_tx1_follows) else $error("first driver not carrier");

  property p_off_low;
    @(posedge hclk) disable iff (!hresetn) !d1_on |=> !first_antenna_output;
  endproperty
  a_off_low: assert property (p_off_low) else $error("first driver active while off");

  property p_off_low2;
    @(posedge hclk) disable iff (!hresetn) !d2_on |=> !second_antenna_output;
  endproperty
  a_off_low2: assert property (p_off_low2) else $error("second driver active while off");

  property p_mod_gs;
    @(posedge hclk) disable iff (!hresetn)
      (hresetn && !envelope) |=> (first_positive_conductance == $past(positive_modulated_setting));
  endproperty
  a_mod_gs: assert property (p_mod_gs) else $error("modulation setting not chosen");

  property p_cw_gs;
    @(posedge hclk) disable iff (!hresetn)
      (hresetn && envelope) |=> (first_negative_array_conductance == $past(negative_unmodulated_setting));
  endproperty
  a_cw_gs: assert property (p_cw_gs) else $error("unmodulated setting not chosen");

  property p_cw2_gs;
    @(posedge hclk) disable iff (!hresetn)
      second_driver_unmodulated |=> (second_positive_conductance == $past(positive_unmodulated_setting));
  endproperty
  a_cw2_gs: assert property (p_cw2_gs) else $error("second driver not on unmodulated setting");

  property p_shared_gs;
    @(posedge hclk) disable iff (!hresetn)
      !second_driver_unmodulated |=> (second_positive_conductance == first_positive_conductance &&
        second_negative_array_conductance == first_negative_array_conductance);
  endproperty
  a_shared_gs: assert property (p_shared_gs) else $error("drivers use different settings");

  property p_force1;
    @(posedge hclk) disable iff (!hresetn)
      (force_full_depth_keying && !envelope) |=> !first_antenna_output;
  endproperty
  a_force1: assert property (p_force1) else $error("first driver not held low");

  property p_force2;
    @(posedge hclk) disable iff (!hresetn)
      (force_full_depth_keying && !second_driver_unmodulated && !envelope) |=> !second_antenna_output;
  endproperty
  a_force2: assert property (p_force2) else $error("second driver not held low");

  property p_miller;
    @(posedge hclk) disable iff (!hresetn)
      (modem_output_select_q == RFD_MOUT_MILLER) |=> (modem_output_pin == $past(miller_coder_out));
  endproperty
  a_miller: assert property (p_miller) else $error("modem pin not miller");

  property p_rxsrc;
    @(posedge hclk) disable iff (!hresetn)
      (receive_source_select_q == RFD_RXSRC_MODEM) |=> (decoder_input == $past(min_stable_q));
  endproperty
  a_rxsrc: assert property (p_rxsrc) else $error("decoder not from modem pin");
endmodule // rfd_signal_select
`default_nettype wire

//--- rfd_antenna_model.sv
// rfd_antenna_model: far side of the driver pins, passive network and active antenna
// assumes the bench sets the reply levels; replies arrive LAG cycles late
`timescale 1ns/1ns
`default_nettype none
module rfd_antenna_model #(
  parameter int LAG = 2
) (
  input wire logic hclk,
  input wire logic first_antenna_output,
  input wire logic second_antenna_output,
  input wire logic modem_output_pin,
  input wire logic passive_reply,
  input wire logic active_reply,
  output logic analog_rx_in,
  output logic modem_input_pin
);
  logic [7:0] rx_q = 8'h00;
  logic [7:0] mf_q = 8'h00;
  // both antennas stay wired at once; the host uses one path at a time
  always_ff @(posedge hclk) begin
    rx_q <= {rx_q[6:0], passive_reply};
    mf_q <= {mf_q[6:0], active_reply};
  end
  assign analog_rx_in = rx_q[LAG-1];
  assign modem_input_pin = mf_q[LAG-1];
endmodule // rfd_antenna_model
`default_nettype wire

//--- rfd_signal_select_tb.sv
// rfd_signal_select_tb: random and corner checks of driver waveform, conductance and routing
// assumes one AHB-Lite master (this bench) and the antenna model on the far side
`timescale 1ns/1ns
`default_nettype none
module rfd_signal_select_tb;
  import rfd_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, env = 0, mil = 0, prep = 0, arep = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic [31:0] hwdata = 0, hrdata, rd, gs;
  logic hreadyout, hresp, tx1, tx2, mfo, dec, arx, mfi, a1, a2, b1, b2;
  logic [5:0] p1, n1, p2, n2;
  logic [7:0] ctl;
  logic [7:0] corner [4] = '{8'hF7, 8'hF7, 8'h3B, 8'h01};
  logic [3:0] msel [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
  int error_cnt = 0, num_checks = 0, c1, c2;
  rfd_signal_select dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .coder_envelope(env), .miller_coder_out(mil),
    .modem_input_pin(mfi), .analog_rx_in(arx), .first_antenna_output(tx1), .second_antenna_output(tx2),
    .first_positive_conductance(p1), .first_negative_array_conductance(n1),
    .second_positive_conductance(p2), .second_negative_array_conductance(n2),
    .modem_output_pin(mfo), .decoder_input(dec));
  rfd_antenna_model #(.LAG(2)) ant_u (.hclk(hclk), .first_antenna_output(tx1), .second_antenna_output(tx2),
    .modem_output_pin(mfo), .passive_reply(prep), .active_reply(arep), .analog_rx_in(arx),
    .modem_input_pin(mfi));
  ////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one single word transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string m);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask
  // waveform code per driver: 0 carrier, 1 inverted carrier, 2 held low
  function automatic int code1(input logic [7:0] c, input logic e);
    if (c[RFD_B_FORCE] && !e) return 2;
    return (c[RFD_B_FORCE] && c[RFD_B_D1_INV_ON]) ? 1 : 0;
  endfunction
  function automatic int code2(input logic [7:0] c, input logic e);
    if (!c[RFD_B_D2_CW] && c[RFD_B_FORCE] && !e) return 2;
    return c[RFD_B_D2_INV_ON] ? 1 : 0;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    conclude();
  end
  initial begin
    void'($urandom(32'hbfcb));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(RFD_TXCTRL_OFS, 32'(RFD_TXCTRL_RST), "ctrl reset");
    rdc(RFD_GS_OFS, RFD_GS_RST, "gs reset");
    rdc(RFD_TXSEL_OFS, 32'h0, "txsel reset");
    rdc(RFD_RXSEL_OFS, 32'h0, "rxsel reset");
    ahb(1'b1, 8'h14, 32'hFFFFFFFF);
    rdc(8'h14, 32'h0, "unmapped");
    ahb(1'b0, RFD_STATUS_OFS, 32'h0);
    chk((rd >> 16) & 32'hFFF, RFD_MAX_KBPS, "rate field");
    chk(hresp, 1'b0, "hresp");
    gs = $urandom() & 32'h3F3F3F3F;
    ahb(1'b1, RFD_GS_OFS, gs);
    rdc(RFD_GS_OFS, gs, "gs readback");
    for (int i = 0; i < 40; i++) begin
      ctl = (i < 4) ? corner[i] : (8'($urandom()) | 8'h01);
      ahb(1'b1, RFD_TXCTRL_OFS, {24'h0, ctl});
      env <= (i < 4) ? i[0] : 1'($urandom());
      repeat (3) @(posedge hclk);
      a1 = tx1;
      a2 = tx2;
      @(posedge hclk);
      b1 = tx1;
      b2 = tx2;
      c1 = code1(ctl, env);
      c2 = code2(ctl, env);
      chk(b1, (c1 == 2) ? 1'b0 : 1'(~a1), "tx1 wave");
      if (ctl[RFD_B_D2_ON]) begin
        chk(b2, (c2 == 2) ? 1'b0 : 1'(~a2), "tx2 wave");
        if (c1 != 2 && c2 != 2) chk(b2, b1 ^ (c1 != c2), "tx2 phase");
      end else begin
        chk(b2, 1'b0, "tx2 off");
      end
      chk(p1, env ? gs[5:0] : gs[13:8], "p cond");
      chk(n1, env ? gs[21:16] : gs[29:24], "n cond");
      if (!ctl[RFD_B_D2_CW]) chk({p2, n2}, {p1, n1}, "shared cond");
      else chk({p2, n2}, {gs[5:0], gs[21:16]}, "cw2 cond");
    end
    for (int i = 0; i < 24; i++) begin
      ahb(1'b1, RFD_TXSEL_OFS, {28'h0, msel[i % 4]});
      mil <= 1'($urandom());
      env <= 1'($urandom());
      prep <= 1'($urandom());
      repeat (6) @(posedge hclk);
      chk(mfo, (msel[i % 4] == RFD_MOUT_MILLER) ? mil : (msel[i % 4] == RFD_MOUT_ENV) ? env :
        (msel[i % 4] == RFD_MOUT_RXIN) ? prep : 1'b0, "modem out");
    end
    // driver envelope taken from the modem pin instead of the coder
    ahb(1'b1, RFD_TXSEL_OFS, 32'h0000_0010);
    for (int i = 0; i < 8; i++) begin
      arep <= 1'($urandom());
      repeat (10) @(posedge hclk);
      chk(p1, arep ? gs[5:0] : gs[13:8], "modem envelope");
    end
    for (int i = 0; i < 16; i++) begin
      ahb(1'b1, RFD_RXSEL_OFS, {30'h0, i[0] ? RFD_RXSRC_MODEM : RFD_RXSRC_INT});
      arep <= 1'($urandom());
      prep <= 1'($urandom());
      repeat (10) @(posedge hclk);
      chk(dec, i[0] ? arep : prep, "decoder src");
    end
    conclude();
  end
endmodule // rfd_signal_select_tb
`default_nettype wire
